// ===== rtl/vrc_pin_mux.sv
`timescale 1ns/1ps
`include "vrc_map.svh"
// pin direction override for the shared analog pin
module vrc_pin_mux
    import vrc_pkg::*;
(
    input wire logic pin_oe,
    input wire logic port_dir_in,
    output logic pin_analog_connect,
    output logic pin_dir_eff
);
    // reference routing wins over the direction latch
    always_comb begin
        pin_analog_connect = pin_oe;
        pin_dir_eff = pin_oe ? 1'b1 : port_dir_in;
    end
endmodule

// ===== rtl/vrc_top.sv
`timescale 1ns/1ps
`include "vrc_map.svh"
module vrc_top
    import vrc_pkg::*;
(
    input wire logic clk,
    input wire logic nrst,
    input wire vrc_addr_t addr,
    input wire vrc_byte_t wdata,
    input wire logic wr,
    input wire logic rd,
    input wire logic port_a_direction,
    output vrc_byte_t rdata,
    output logic ref_power_enable,
    output logic ref_pin_output_enable,
    output logic ref_range_select,
    output logic ref_source_select,
    output vrc_tap_t ref_tap_value,
    output logic shared_analog_pin_connect,
    output logic shared_analog_pin_dir
);
    vrc_byte_t voltage_ref_control;
    vrc_byte_t next_voltage_ref_control;
    vrc_byte_t next_rdata;
    logic pin_connect_c;
    logic pin_dir_c;
    logic pin_connect_q;
    logic pin_dir_q;

    // software write; no sleep input exists so wake keeps state
    always_comb begin
        next_voltage_ref_control = voltage_ref_control;
        if (wr && addr == `VRC_ADDR_CTRL) begin
            next_voltage_ref_control = wdata;
        end
    end

    // read path, data one cycle after strobe
    always_comb begin
        next_rdata = 8'h00;
        if (rd) begin
            case (addr)
                `VRC_ADDR_CTRL: next_rdata = voltage_ref_control;
                `VRC_ADDR_STATUS: next_rdata = {6'h00, pin_dir_q,
                                                pin_connect_q};
                default: next_rdata = 8'h00;
            endcase
        end
    end

    // shared pin routing and direction override
    vrc_pin_mux u_pin_mux (
        .pin_oe(voltage_ref_control[`VRC_BIT_PIN_OE]),
        .port_dir_in(port_a_direction),
        .pin_analog_connect(pin_connect_c),
        .pin_dir_eff(pin_dir_c)
    );

    // control register and registered outputs
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            voltage_ref_control <= `VRC_CTRL_RESET;
            rdata <= 8'h00;
            pin_connect_q <= 1'b0;
            pin_dir_q <= 1'b0;
        end else begin
            voltage_ref_control <= next_voltage_ref_control;
            rdata <= next_rdata;
            pin_connect_q <= pin_connect_c;
            pin_dir_q <= pin_dir_c;
        end
    end

    // settings to the ladder, independent of any comparator mode
    always_comb begin
        ref_power_enable = voltage_ref_control[`VRC_BIT_POWER];
        ref_pin_output_enable = voltage_ref_control[`VRC_BIT_PIN_OE];
        ref_range_select = voltage_ref_control[`VRC_BIT_RANGE];
        ref_source_select = voltage_ref_control[`VRC_BIT_SOURCE];
        ref_tap_value = voltage_ref_control[`VRC_TAP_MSB:`VRC_TAP_LSB];
        shared_analog_pin_connect = pin_connect_q;
        shared_analog_pin_dir = pin_dir_q;
    end

    // a control write lands on the next edge
    chk_write_takes: assert property (
        @(posedge clk) disable iff (!nrst)
        wr && addr == `VRC_ADDR_CTRL |=>
        voltage_ref_control == $past(wdata))
        else $error("control write not stored");

    // no write, no change: sleep and wake keep the settings
    chk_hold_value: assert property (
        @(posedge clk) disable iff (!nrst)
        !(wr && addr == `VRC_ADDR_CTRL) |=>
        $stable(voltage_ref_control))
        else $error("control changed without write");

    // control readback one cycle after the strobe
    chk_read_data: assert property (
        @(posedge clk) disable iff (!nrst)
        rd && addr == `VRC_ADDR_CTRL && !wr |=>
        rdata == $past(voltage_ref_control))
        else $error("readback mismatch");

    // pin routing follows the enable one cycle later
    chk_pin_connect: assert property (
        @(posedge clk) disable iff (!nrst)
        ##1 shared_analog_pin_connect ==
        $past(ref_pin_output_enable))
        else $error("pin connect wrong");

    // enable forces the pin direction
    chk_dir_override: assert property (
        @(posedge clk) disable iff (!nrst)
        ref_pin_output_enable |=>
        shared_analog_pin_dir)
        else $error("direction not overridden");

    // without enable the port direction passes through
    chk_dir_pass: assert property (
        @(posedge clk) disable iff (!nrst)
        nrst && !ref_pin_output_enable |=>
        shared_analog_pin_dir == $past(port_a_direction))
        else $error("direction not passed");

    // power bit written from data bit 7
    chk_power_bit: assert property (
        @(posedge clk) disable iff (!nrst)
        wr && addr == `VRC_ADDR_CTRL |=>
        ref_power_enable == $past(wdata[`VRC_BIT_POWER]))
        else $error("power bit wrong");

    // range, source and tap fields written together
    chk_range_tap: assert property (
        @(posedge clk) disable iff (!nrst)
        wr && addr == `VRC_ADDR_CTRL |=>
        ref_range_select == $past(wdata[`VRC_BIT_RANGE]) &&
        ref_source_select == $past(wdata[`VRC_BIT_SOURCE]) &&
        ref_tap_value == $past(wdata[3:0]))
        else $error("range, source or tap wrong");

    // read data is zero outside the read answer
    chk_idle_zero: assert property (
        @(posedge clk) disable iff (!nrst)
        !rd |=>
        rdata == 8'h00)
        else $error("read data not zero");

    // power enable held clear in reset
    chk_reset_power: assert property (
        @(posedge clk)
        !nrst |->
        !ref_power_enable)
        else $error("power enable not cleared by reset");

    // pin output enable held clear in reset
    chk_reset_pin_oe: assert property (
        @(posedge clk)
        !nrst |->
        !ref_pin_output_enable)
        else $error("pin enable not cleared by reset");

    // high range selected in reset
    chk_reset_range: assert property (
        @(posedge clk)
        !nrst |->
        !ref_range_select)
        else $error("range not cleared by reset");

    // tap value zero in reset
    chk_reset_tap: assert property (
        @(posedge clk)
        !nrst |->
        ref_tap_value == 4'h0)
        else $error("tap not cleared by reset");

    // pin cut off and released in reset
    chk_reset_pins: assert property (
        @(posedge clk)
        !nrst |->
        !shared_analog_pin_connect && !shared_analog_pin_dir)
        else $error("pin outputs not cleared by reset");

    // read data quiet in reset
    chk_reset_rdata: assert property (
        @(posedge clk)
        !nrst |->
        rdata == 8'h00)
        else $error("read data not cleared by reset");

    // whole register at its reset value right after release
    chk_release_clear: assert property (
        @(posedge clk)
        !nrst ##1 nrst |->
        voltage_ref_control == `VRC_CTRL_RESET)
        else $error("control not clear after reset");

    // enable set routes the level to the pin
    chk_pin_route: assert property (
        @(posedge clk) disable iff (!nrst)
        ref_pin_output_enable |=>
        shared_analog_pin_connect)
        else $error("pin not connected");

    // enable clear cuts the pin off
    chk_pin_cut: assert property (
        @(posedge clk) disable iff (!nrst)
        !ref_pin_output_enable |=>
        !shared_analog_pin_connect)
        else $error("pin not disconnected");

    // settled enable and routing agree
    chk_connect_settled: assert property (
        @(posedge clk) disable iff (!nrst)
        $past(nrst) && $stable(ref_pin_output_enable) |->
        shared_analog_pin_connect == ref_pin_output_enable)
        else $error("settled pin connect wrong");

    // settled direction follows the port when not overridden
    chk_dir_settled: assert property (
        @(posedge clk) disable iff (!nrst)
        $past(nrst) && !ref_pin_output_enable &&
        $stable(ref_pin_output_enable) && $stable(port_a_direction) |->
        shared_analog_pin_dir == port_a_direction)
        else $error("settled direction wrong");

    // status read shows the registered pin state
    chk_status_read: assert property (
        @(posedge clk) disable iff (!nrst)
        rd && addr == `VRC_ADDR_STATUS && !wr |=>
        rdata == {6'h00, $past(shared_analog_pin_dir),
                  $past(shared_analog_pin_connect)})
        else $error("status readback mismatch");

    // unmapped reads return zero
    chk_unmapped_read: assert property (
        @(posedge clk) disable iff (!nrst)
        rd && addr != `VRC_ADDR_CTRL &&
        addr != `VRC_ADDR_STATUS |=>
        rdata == 8'h00)
        else $error("unmapped read not zero");

    // unmapped writes are ignored
    chk_unmapped_write: assert property (
        @(posedge clk) disable iff (!nrst)
        wr && addr != `VRC_ADDR_CTRL |=>
        $stable(voltage_ref_control))
        else $error("unmapped write changed control");

    // settings to the ladder stand until a write
    chk_settings_stand: assert property (
        @(posedge clk) disable iff (!nrst)
        !(wr && addr == `VRC_ADDR_CTRL) |=>
        $stable({ref_power_enable, ref_pin_output_enable,
                 ref_range_select, ref_source_select, ref_tap_value}))
        else $error("settings changed without write");

    // read right behind a write returns the new value
    chk_write_then_read: assert property (
        @(posedge clk) disable iff (!nrst)
        wr && addr == `VRC_ADDR_CTRL ##1
        rd && addr == `VRC_ADDR_CTRL |=>
        rdata == $past(wdata, 2))
        else $error("read after write stale");

    // pin enable written from data bit 6
    chk_oe_write: assert property (
        @(posedge clk) disable iff (!nrst)
        wr && addr == `VRC_ADDR_CTRL |=>
        ref_pin_output_enable == $past(wdata[`VRC_BIT_PIN_OE]))
        else $error("pin enable bit wrong");

    // range select written from data bit 5
    chk_range_write: assert property (
        @(posedge clk) disable iff (!nrst)
        wr && addr == `VRC_ADDR_CTRL |=>
        ref_range_select == $past(wdata[`VRC_BIT_RANGE]))
        else $error("range bit wrong");

    // source select written from data bit 4
    chk_source_write: assert property (
        @(posedge clk) disable iff (!nrst)
        wr && addr == `VRC_ADDR_CTRL |=>
        ref_source_select == $past(wdata[`VRC_BIT_SOURCE]))
        else $error("source bit wrong");

    // each control bit written and held on its own
    for (genvar b = 0; b < 8; b++) begin : g_bit_chk
        chk_bit_write: assert property (
            @(posedge clk) disable iff (!nrst)
            wr && addr == `VRC_ADDR_CTRL |=>
            voltage_ref_control[b] == $past(wdata[b]))
            else $error("control bit not stored");
        chk_bit_hold: assert property (
            @(posedge clk) disable iff (!nrst)
            !(wr && addr == `VRC_ADDR_CTRL) |=>
            voltage_ref_control[b] == $past(voltage_ref_control[b]))
            else $error("control bit changed without write");
    end

    // main scenarios
    cov_enable_pin: cover property (@(posedge clk) disable iff (!nrst)
        ref_power_enable && ref_pin_output_enable);
    cov_low_range: cover property (@(posedge clk) disable iff (!nrst)
        ref_range_select && ref_tap_value == 4'hF);
    cov_write_read: cover property (@(posedge clk) disable iff (!nrst)
        wr ##1 rd);
    cov_status_read: cover property (@(posedge clk) disable iff (!nrst)
        rd && addr == `VRC_ADDR_STATUS);
    cov_dir_override: cover property (@(posedge clk) disable iff (!nrst)
        ref_pin_output_enable && !port_a_direction);
endmodule

// ===== shared/vrc_map.svh
// Function
// - pin output enable set routes the reference level to the shared pin.
// - reset clears the power enable bit 7.
// - reset clears the pin output enable bit 6.
// - reset clears the range select bit 5, choosing the high range.
// - reset clears the 4-bit tap value.
// - waking from sleep leaves every control bit unchanged.
// - the reference settings act independently of the comparator mode.
// - range select 1 picks the fine low range, 0 the offset high range.
// - source select picks the main rails or the external reference pins.
`ifndef VRC_MAP_SVH
`define VRC_MAP_SVH
`define VRC_ADDR_CTRL 4'h0
`define VRC_ADDR_STATUS 4'h1
`define VRC_CTRL_RESET 8'h00
`define VRC_BIT_POWER 7
`define VRC_BIT_PIN_OE 6
`define VRC_BIT_RANGE 5
`define VRC_BIT_SOURCE 4
`define VRC_TAP_MSB 3
`define VRC_TAP_LSB 0
`endif

// ===== shared/vrc_pkg.sv
package vrc_pkg;
    typedef logic [7:0] vrc_byte_t;
    typedef logic [3:0] vrc_addr_t;
    typedef logic [3:0] vrc_tap_t;
endpackage

// ===== testbench/testbench.sv
`timescale 1ns/1ps
module testbench
    import vrc_pkg::*;
;
    logic clk = 1'b0;
    logic nrst = 1'b1;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic port_a_direction = 1'b0;
    vrc_addr_t addr = 4'h0;
    vrc_byte_t wdata = 8'h00, rdata, settings, pins;
    logic p_en, p_oe, p_rng, p_src, p_con, p_dir;
    vrc_tap_t p_tap;
    int err_total = 0, n_compared = 0;
    vrc_top i_dut(.clk(clk), .nrst(nrst), .addr(addr), .wdata(wdata),
        .wr(wr), .rd(rd), .port_a_direction(port_a_direction),
        .rdata(rdata), .ref_power_enable(p_en), .ref_pin_output_enable(p_oe),
        .ref_range_select(p_rng), .ref_source_select(p_src),
        .ref_tap_value(p_tap), .shared_analog_pin_connect(p_con),
        .shared_analog_pin_dir(p_dir));
    // settings and pin outputs gathered as bytes
    assign settings = {p_en, p_oe, p_rng, p_src, p_tap};
    assign pins = {6'h00, p_dir, p_con};
    // 50 ns clock
    initial begin
        forever #25 clk = ~clk;
    end
    task automatic chk(input vrc_byte_t got, input vrc_byte_t exp);
        n_compared++;
        if (got !== exp) begin
            err_total++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    // one-cycle write strobe
    task automatic wr_reg(input vrc_addr_t a, input vrc_byte_t d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        #1;
    endtask
    // read, data sampled in the following cycle
    task automatic rd_reg(input vrc_addr_t a, input vrc_byte_t exp);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 chk(rdata, exp);
    endtask
    task automatic tally_and_finish;
        if (err_total == 0 && n_compared > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    // watchdog, tests need about 110 cycles
    initial begin
        #100000;
        err_total++;
        tally_and_finish();
    end
    // main sequence
    initial begin
        nrst <= 1'b0;
        repeat (10) @(posedge clk);
        nrst <= 1'b1;
        #1 chk(settings, 8'h00);
        rd_reg(4'h0, 8'h00);
        wr_reg(4'h0, 8'hC5);
        chk(settings, 8'hC5);
        rd_reg(4'h0, 8'hC5);
        chk(pins, 8'h03);
        @(posedge clk);
        #1 chk(rdata, 8'h00);
        rd_reg(4'h1, 8'h03);
        // write then read with no gap between strobes
        @(posedge clk);
        addr <= 4'h0;
        wdata <= 8'h3C;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 chk(rdata, 8'h3C);
        // walk one bit, toggling the port direction alongside
        for (int i = 0; i < 8; i++) begin
            @(posedge clk);
            port_a_direction <= i[0];
            wr_reg(4'h0, 8'h01 << i);
            chk(settings, 8'h01 << i);
            @(posedge clk);
            #1 chk(pins, {6'h00, (i == 6) | i[0], i == 6});
        end
        wr_reg(4'h9, 8'hFF);
        rd_reg(4'h0, 8'h80);
        rd_reg(4'h9, 8'h00);
        wr_reg(4'h0, 8'h5A);
        repeat (40) @(posedge clk);
        #1 chk(settings, 8'h5A);
        wr_reg(4'h0, 8'hFF);
        @(posedge clk);
        nrst <= 1'b0;
        #1 chk(settings, 8'h00);
        chk(pins, 8'h00);
        @(posedge clk);
        nrst <= 1'b1;
        rd_reg(4'h0, 8'h00);
        tally_and_finish();
    end
endmodule
